// *** phase_offset_ctrl.sv ***
// Phase offset control: programmed offset with ramping, and build-out mean error trim.
// Assumes an APB master on pclk and a loop-locked level from the DPLL on the same clock.
`timescale 1ns/1ns
`default_nettype none

// Operation
// - The upper offset byte supplies bits 15 to 8 of the 16-bit phase offset.
// - A new offset written while locked is approached step by step, not jumped to.
// - Software may disable ramping, which is only safe for changes made in holdover.
// - While phase build-out is enabled in either monitor, the programmed offset is ignored.
// - Each build-out event may leave a residual phase error of up to 5 ns.
// - With zero trim the mean residual error over many build-out events is zero.
// - The trim is added as a fixed offset on every build-out event.
// - The six-bit trim is two's complement, 0.101 ns per step.
module phase_offset_ctrl #(
	parameter int RAMP_DIV = phase_offset_pkg::RAMP_DIV_DEFAULT
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        loop_locked,
	input  wire logic        pbo_event,
	output logic      [15:0] applied_offset,
	output logic             phase_build_out_active,
	output logic      [5:0]  pbo_event_trim,
	output logic             pbo_event_strobe
);
	logic [7:0]  offset_high_reg;
	logic [7:0]  offset_low_reg;
	logic [5:0]  trim_reg;
	logic [2:0]  control_reg;
	logic [15:0] applied_reg;
	logic [15:0] applied_next;
	logic [$clog2(RAMP_DIV+1)-1:0] div_reg;
	logic        ramp_tick;
	logic        ramping_reg;
	logic        pbo_sticky_reg;
	logic        pbo_active_reg;

	wire         access     = psel && penable;
	wire         setup_cyc  = psel && !penable;
	wire         wr_en      = access && pwrite;
	wire  [9:0]  word_index = paddr[11:2];
	wire         sel_trim   = word_index == {2'h0, phase_offset_pkg::TRIM_INDEX};
	wire         sel_high   = word_index == {2'h0, phase_offset_pkg::OFFSET_HIGH_INDEX};
	wire         sel_low    = word_index == {2'h0, phase_offset_pkg::OFFSET_LOW_INDEX};
	wire         sel_ctrl   = word_index == {2'h0, phase_offset_pkg::CONTROL_INDEX};
	wire         sel_stat   = word_index == {2'h0, phase_offset_pkg::STATUS_INDEX};
	wire         sel_appl   = word_index == {2'h0, phase_offset_pkg::APPLIED_INDEX};
	wire         mapped     = sel_trim || sel_high || sel_low || sel_ctrl || sel_stat || sel_appl;
	// Writes to the status and applied registers get an error as well; a status write still clears the sticky bit.
	wire         bad_access = !mapped || (pwrite && (sel_stat || sel_appl));

	wire  [15:0] programmed = {offset_high_reg, offset_low_reg};
	wire         pbo_on     = pbo_active_reg;
	wire         pbo_hit    = pbo_event && pbo_on;
	wire         stat_clear = wr_en && sel_stat;
	wire  [15:0] target     = pbo_on ? 16'h0000 : programmed;
	wire         ramp_off   = control_reg[phase_offset_pkg::CTRL_RAMP_DIS_BIT];
	wire         step_mode  = loop_locked && !ramp_off;
	wire         trim_legal = ($signed(trim_reg) <= $signed(phase_offset_pkg::TRIM_MAX_CODE))
	                       && ($signed(trim_reg) >= $signed(phase_offset_pkg::TRIM_MIN_CODE));

	// Ramping moves one LSB per tick; compare as signed since offsets are two's complement.
	always_comb
	begin
		applied_next = applied_reg;
		if (!step_mode)
			applied_next = target;
		else if (ramp_tick && applied_reg != target)
		begin
			if ($signed(target) > $signed(applied_reg))
				applied_next = applied_reg + 16'h0001;
			else
				applied_next = applied_reg - 16'h0001;
		end
	end

	// One step per RAMP_DIV cycles keeps the slope gentle; a large jump takes long to settle.
	assign ramp_tick = div_reg == ($clog2(RAMP_DIV+1))'(RAMP_DIV - 1);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div_reg <= '0;
		else if (ramp_tick)
			div_reg <= '0;
		else
			div_reg <= div_reg + 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			offset_high_reg <= phase_offset_pkg::OFFSET_RESET;
		else if (wr_en && sel_high)
			offset_high_reg <= pwdata[7:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			offset_low_reg <= phase_offset_pkg::OFFSET_RESET;
		else if (wr_en && sel_low)
			offset_low_reg <= pwdata[7:0];
	end

	// Only six bits are stored, so the two unused bits can neither be written nor read back.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			trim_reg <= phase_offset_pkg::TRIM_RESET[5:0];
		else if (wr_en && sel_trim)
			trim_reg <= pwdata[5:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			control_reg <= phase_offset_pkg::CONTROL_RESET;
		else if (wr_en && sel_ctrl)
			control_reg <= pwdata[2:0];
	end

	// The build-out flag is loaded with the control word rather than decoded from it,
	// so the output leaves a flip-flop and still changes in the same cycle as the bits.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pbo_active_reg <= 1'b0;
		else if (wr_en && sel_ctrl)
			pbo_active_reg <= pwdata[phase_offset_pkg::CTRL_PBO_MON_BIT]
			               || pwdata[phase_offset_pkg::CTRL_PBO_PHM_BIT];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			applied_reg <= 16'h0000;
			ramping_reg <= 1'b0;
		end
		else
		begin
			applied_reg <= applied_next;
			ramping_reg <= applied_next != target;
		end
	end

	// The trim rides along with each build-out event as a fixed offset; with zero trim the
	// residual error of the event alone is unbiased, up to 5 ns either way.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pbo_event_strobe <= 1'b0;
		else
			pbo_event_strobe <= pbo_hit;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pbo_event_trim <= phase_offset_pkg::TRIM_RESET[5:0];
		else if (pbo_hit)
			pbo_event_trim <= trim_reg;
	end

	// A new event beats a clear in the same cycle, so no event is lost to that race.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pbo_sticky_reg <= 1'b0;
		else if (pbo_hit)
			pbo_sticky_reg <= 1'b1;
		else if (stat_clear)
			pbo_sticky_reg <= 1'b0;
	end

	wire [31:0] read_word =
		sel_trim ? {26'h0, trim_reg} :
		sel_high ? {24'h0, offset_high_reg} :
		sel_low  ? {24'h0, offset_low_reg} :
		sel_ctrl ? {29'h0, control_reg} :
		sel_stat ? {28'h0, pbo_sticky_reg, !trim_legal, pbo_on, ramping_reg} :
		sel_appl ? {16'h0, applied_reg} :
		32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= setup_cyc;
			pslverr <= setup_cyc && bad_access;
		end
	end

	// Read data is taken in the setup cycle, so it is settled for the whole access cycle.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (setup_cyc && !pwrite)
			prdata <= read_word;
	end

	assign applied_offset         = applied_reg;
	assign phase_build_out_active = pbo_active_reg;
endmodule : phase_offset_ctrl

`default_nettype wire

// *** phase_offset_pkg.sv ***
// Package for the phase offset control block: register offsets, layouts and reset values.
// Assumes a 32-bit APB slave with one aligned word per register.
package phase_offset_pkg;
	// Printed offset 0x72 is not a multiple of four, so it is kept as an index.
	localparam logic [7:0]  TRIM_INDEX        = 8'h72;
	localparam logic [7:0]  OFFSET_HIGH_INDEX = 8'h71;
	localparam logic [7:0]  OFFSET_LOW_INDEX  = 8'h70;
	localparam logic [7:0]  CONTROL_INDEX     = 8'h74;
	localparam logic [7:0]  STATUS_INDEX      = 8'h75;
	localparam logic [7:0]  APPLIED_INDEX     = 8'h76;
	localparam logic [7:0]  TRIM_RESET        = 8'h00;
	localparam logic [7:0]  OFFSET_RESET      = 8'h00;
	localparam logic [2:0]  CONTROL_RESET     = 3'h0;
	localparam int          TRIM_WIDTH        = 6;
	localparam int          CTRL_RAMP_DIS_BIT = 0;
	localparam int          CTRL_PBO_MON_BIT  = 1;
	localparam int          CTRL_PBO_PHM_BIT  = 2;
	localparam logic [5:0]  TRIM_MAX_CODE     = 6'h0d;
	localparam logic [5:0]  TRIM_MIN_CODE     = 6'h33;
	localparam int          RAMP_DIV_DEFAULT  = 16;
endpackage : phase_offset_pkg

// *** phase_offset_asserts.sv ***
// Port checker for phase_offset_ctrl: bus timing, build-out strobe and offset relations.
// Bound to the top module from the testbench file.
`timescale 1ns/1ns
`default_nettype none
module phase_offset_asserts (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        loop_locked,
	input wire logic        pbo_event,
	input wire logic [15:0] applied_offset,
	input wire logic        phase_build_out_active,
	input wire logic [5:0]  pbo_event_trim,
	input wire logic        pbo_event_strobe
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence event_s;
		pbo_event && phase_build_out_active;
	endsequence
	a_ready_after_setup: assert property (setup_s |=> pready) else $error("no ready");
	a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready too long");
	a_err_with_ready: assert property (pslverr |-> pready) else $error("stray error");
	a_strobe_on_event: assert property (event_s |=> pbo_event_strobe)
		else $error("strobe missing");
	a_strobe_has_cause: assert property (pbo_event_strobe |-> $past(pbo_event))
		else $error("strobe without event");
	a_trim_on_event: assert property ($changed(pbo_event_trim) |-> pbo_event_strobe)
		else $error("trim changed without event");
	a_pbo_zero_offset: assert property (!loop_locked && phase_build_out_active
		|=> applied_offset == 16'h0000) else $error("offset not ignored");
	a_read_high_zero: assert property (pready && !pwrite && !pslverr
		|-> prdata[31:16] == 16'h0000) else $error("read upper bits set");
endmodule : phase_offset_asserts
`default_nettype wire

// *** dpll_phase_offset_control_tb.sv ***
// Self-checking bench for phase_offset_ctrl, driving APB and the DPLL-side inputs.
// Assumes the checker module is compiled first; RAMP_DIV is cut to 2 to keep ramps short.
`timescale 1ns/1ns
`default_nettype none
module dpll_phase_offset_control_tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, loop_locked, pbo_event;
	logic        phase_build_out_active, pbo_event_strobe;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd_data;
	logic [15:0] applied_offset;
	logic [5:0]  pbo_event_trim;
	int          n_mismatch, comparisons;
	phase_offset_ctrl #(.RAMP_DIV(2)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .loop_locked(loop_locked), .pbo_event(pbo_event),
		.applied_offset(applied_offset), .phase_build_out_active(phase_build_out_active),
		.pbo_event_trim(pbo_event_trim), .pbo_event_strobe(pbo_event_strobe));
	initial
	begin
		pclk = 0;
		forever #50 pclk = ~pclk;
	end
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] idx, input logic [31:0] wd, input logic err);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1;
		// No cycle count is assumed; only the watchdog ends a wait that never ends.
		do
		begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd_data = prdata;
		chk("pslverr", {31'h0, err}, {31'h0, pslverr});
		psel <= 0;
		penable <= 0;
	endtask : apb
	task rd(input logic [7:0] idx, input logic [31:0] exp);
		apb(0, idx, 32'h0, 0);
		chk("prdata", exp, rd_data);
	endtask : rd
	task t_regs;
		rd(phase_offset_pkg::TRIM_INDEX, 32'h0);
		apb(1, phase_offset_pkg::TRIM_INDEX, 32'hff, 0);
		rd(phase_offset_pkg::TRIM_INDEX, 32'h3f);
		apb(0, 8'h7f, 32'h0, 1);
		apb(1, phase_offset_pkg::APPLIED_INDEX, 32'h5, 1);
	endtask : t_regs
	task t_offset;
		apb(1, phase_offset_pkg::OFFSET_HIGH_INDEX, 32'h12, 0);
		apb(1, phase_offset_pkg::OFFSET_LOW_INDEX, 32'h34, 0);
		rd(phase_offset_pkg::APPLIED_INDEX, 32'h1234);
		loop_locked <= 1;
		apb(1, phase_offset_pkg::OFFSET_LOW_INDEX, 32'h37, 0);
		repeat (3) @(posedge pclk);
		chk("ramp up", 32'h1235, {16'h0, applied_offset});
		repeat (10) @(posedge pclk);
		chk("ramp end", 32'h1237, {16'h0, applied_offset});
		apb(1, phase_offset_pkg::OFFSET_LOW_INDEX, 32'h35, 0);
		rd(phase_offset_pkg::STATUS_INDEX, 32'h1);
		repeat (6) @(posedge pclk);
		chk("ramp down", 32'h1235, {16'h0, applied_offset});
		rd(phase_offset_pkg::STATUS_INDEX, 32'h0);
		apb(1, phase_offset_pkg::CONTROL_INDEX, 32'h1, 0);
		apb(1, phase_offset_pkg::OFFSET_LOW_INDEX, 32'h30, 0);
		repeat (2) @(posedge pclk);
		chk("step", 32'h1230, {16'h0, applied_offset});
	endtask : t_offset
	task t_pbo;
		for (int b = 1; b < 4; b++)
		begin
			loop_locked <= 0;
			apb(1, phase_offset_pkg::CONTROL_INDEX, (32'h1 << b) & 32'h6, 0);
			apb(1, phase_offset_pkg::TRIM_INDEX,
				b == 1 ? 32'h33 : b == 2 ? 32'h0d : 32'h05, 0);
			chk("applied", b < 3 ? 32'h0 : 32'h1230, {16'h0, applied_offset});
			chk("active", b < 3, {31'h0, phase_build_out_active});
			pbo_event <= 1;
			@(posedge pclk);
			pbo_event <= 0;
			@(posedge pclk);
			chk("strobe", b < 3, {31'h0, pbo_event_strobe});
			chk("trim", b == 1 ? 32'h33 : 32'h0d, {26'h0, pbo_event_trim});
			@(posedge pclk);
			chk("strobe end", 32'h0, {31'h0, pbo_event_strobe});
			rd(phase_offset_pkg::STATUS_INDEX, b < 3 ? 32'ha : 32'h0);
			apb(1, phase_offset_pkg::STATUS_INDEX, 32'h0, 1);
			rd(phase_offset_pkg::STATUS_INDEX, b < 3 ? 32'h2 : 32'h0);
		end
	endtask : t_pbo
	task test_done;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : test_done
	initial
	begin
		{presetn, psel, penable, pwrite, loop_locked, pbo_event} = 6'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		n_mismatch = 0;
		comparisons = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1;
		t_regs();
		t_offset();
		t_pbo();
		test_done();
	end
	initial
	begin
		#3000000;
		n_mismatch++;
		test_done();
	end
endmodule : dpll_phase_offset_control_tb
bind phase_offset_ctrl phase_offset_asserts chk_i (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .loop_locked(loop_locked), .pbo_event(pbo_event),
	.applied_offset(applied_offset), .phase_build_out_active(phase_build_out_active),
	.pbo_event_trim(pbo_event_trim), .pbo_event_strobe(pbo_event_strobe));
`default_nettype wire
